/* File: hdl/atf_pkg.sv */
// package for the address table flush, aging and event register bank
// assumes one 200 MHz clock, APB with 32-bit data, word-aligned registers
`default_nettype none
package atf_pkg;
  // register indices, byte address is four times the index
  localparam logic [11:0] ATF_IDX_FLUSH_TRIG  = 12'h311;
  localparam logic [11:0] ATF_IDX_SCOPE_PRIO  = 12'h312;
  localparam logic [11:0] ATF_IDX_AGE_PERIOD  = 12'h313;
  localparam logic [11:0] ATF_IDX_EVT_STATUS  = 12'h314;
  localparam logic [11:0] ATF_IDX_EVT_MASK    = 12'h315;
  localparam logic [11:0] ATF_IDX_WR_INDEX    = 12'h316;
  localparam logic [11:0] ATF_IDX_LEARN_INDEX = 12'h318;
  localparam int          ATF_ADDR_W          = 14;
  // field positions
  localparam int ATF_TRIG_WHOLE  = 0;
  localparam int ATF_TRIG_MSTP   = 1;
  localparam int ATF_SCOPE_LSB   = 2;
  localparam int ATF_PSRC_LSB    = 0;
  localparam int ATF_EVT_WR_FAIL = 0;
  localparam int ATF_EVT_ALMOST  = 1;
  localparam int ATF_EVT_LEARN   = 2;
  localparam int ATF_EVT_N       = 3;
  // reset values
  localparam logic [7:0] ATF_RST_AGE   = 8'h4b;
  localparam logic [7:0] ATF_RST_CTRL2 = 8'h00;
  localparam logic [2:0] ATF_RST_MASK  = 3'h7;
  localparam logic [1:0] ATF_TRIG_RST  = 2'h0;
  // almost-full window of prior entries
  localparam logic [2:0] ATF_ALMOST_LO = 3'h2;
  localparam logic [2:0] ATF_ALMOST_HI = 3'h3;
  // timing: one age unit in seconds, clock in MHz
  localparam int ATF_AGE_UNIT_S   = 1;
  localparam int ATF_CLK_MHZ      = 200;
  localparam int ATF_SEC_CYCLES   = ATF_AGE_UNIT_S * ATF_CLK_MHZ * 1000000;
  // flush scope and priority source encodings
  typedef enum logic [1:0] {
    ATF_SCOPE_NONE = 2'h0, ATF_SCOPE_DYN = 2'h1,
    ATF_SCOPE_STAT = 2'h2, ATF_SCOPE_BOTH = 2'h3
  } atf_scope_t;
  typedef enum logic [1:0] {
    ATF_PSRC_DA = 2'h0, ATF_PSRC_SA = 2'h1,
    ATF_PSRC_MAX = 2'h2, ATF_PSRC_MIN = 2'h3
  } atf_psrc_t;
  // events reported by the lookup engine
  typedef struct packed {
    logic        learn_fail;
    logic [9:0]  learn_bucket;
    logic        st_wr_ok;
    logic [2:0]  st_wr_prior;
    logic [11:0] st_wr_entry;
    logic        st_wr_fail;
    logic [9:0]  st_fail_bucket;
  } atf_evt_t;
  // flush command towards the table
  typedef struct packed {
    logic active;
    logic dynamic;
    logic stat;
    logic mstp_only;
  } atf_flush_t;
endpackage
`default_nettype wire

/* File: hdl/atf_regs.sv */
// register bank: flush scope, address priority source, aging tick, table events
// assumes events and lookup priorities arrive on mclk, rst synchronous
`timescale 1ns/1ps
`default_nettype none
module atf_regs
  import atf_pkg::*;
#(
  parameter int PRIO_W     = 2,
  parameter int SEC_CYCLES = ATF_SEC_CYCLES
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic      [31:0]       prdata,
  input  wire atf_evt_t          evt,
  input  wire logic [PRIO_W-1:0] da_prio,
  input  wire logic [PRIO_W-1:0] sa_prio,
  output logic      [PRIO_W-1:0] address_based_priority,
  output atf_flush_t             flush_cmd,
  input  wire logic              flush_done,
  output logic      [7:0]        age_period,
  output logic                   age_tick,
  output logic                   lookup_engine_summary_interrupt,
  output logic                   irq
);

  // parameter checks at elaboration
  if (PRIO_W < 1 || PRIO_W > 8) begin : g_bad_prio
    $error("PRIO_W out of range");
  end
  if (SEC_CYCLES < 1) begin : g_bad_sec
    $error("SEC_CYCLES must be positive");
  end

  // register select from a byte address
  function automatic logic hit(input logic [31:0] a, input logic [11:0] idx);
    hit = (a[1:0] == 2'h0) && (a[31:2] == {18'h0, idx});
  endfunction

  logic [1:0]          trig_q;
  logic [7:0]          ctrl2_q;
  logic [7:0]          age_q;
  logic [ATF_EVT_N-1:0] sts_q;
  logic [ATF_EVT_N-1:0] sts_d;
  logic [ATF_EVT_N-1:0] mask_q;
  logic [15:0]         wr_idx_q;
  logic [15:0]         learn_idx_q;
  logic [31:0]         prdata_q;
  logic                pslverr_q;
  logic [31:0]         sec_cnt_q;
  logic [7:0]          age_cnt_q;
  logic                age_tick_q;
  logic [PRIO_W-1:0]   prio_q;
  logic                wr_en;
  logic                setup;
  logic                mapped;
  logic [ATF_EVT_N-1:0] evt_set;
  logic                almost_ev;
  atf_scope_t          scope;
  atf_psrc_t           psrc;

  assign setup  = psel && !penable;
  assign wr_en  = psel && penable && pwrite;
  assign mapped = hit(paddr, ATF_IDX_FLUSH_TRIG) || hit(paddr, ATF_IDX_SCOPE_PRIO)
               || hit(paddr, ATF_IDX_AGE_PERIOD) || hit(paddr, ATF_IDX_EVT_STATUS)
               || hit(paddr, ATF_IDX_EVT_MASK)   || hit(paddr, ATF_IDX_WR_INDEX)
               || hit(paddr, ATF_IDX_LEARN_INDEX);
  assign scope  = atf_scope_t'(ctrl2_q[ATF_SCOPE_LSB +: 2]);
  assign psrc   = atf_psrc_t'(ctrl2_q[ATF_PSRC_LSB +: 2]);

  // zero-wait slave
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // read data captured in the setup cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= !mapped;
      prdata_q  <= 32'h0;
      if (!pwrite) begin
        if (hit(paddr, ATF_IDX_FLUSH_TRIG))  prdata_q <= {30'h0, trig_q};
        if (hit(paddr, ATF_IDX_SCOPE_PRIO))  prdata_q <= {24'h0, ctrl2_q};
        if (hit(paddr, ATF_IDX_AGE_PERIOD))  prdata_q <= {24'h0, age_q};
        if (hit(paddr, ATF_IDX_EVT_STATUS))  prdata_q <= {29'h0, sts_q};
        if (hit(paddr, ATF_IDX_EVT_MASK))    prdata_q <= {29'h0, mask_q};
        if (hit(paddr, ATF_IDX_WR_INDEX))    prdata_q <= {16'h0, wr_idx_q};
        if (hit(paddr, ATF_IDX_LEARN_INDEX)) prdata_q <= {16'h0, learn_idx_q};
      end
    end
  end

  // flush scope and priority source
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl2_q <= ATF_RST_CTRL2;
    end else if (wr_en && hit(paddr, ATF_IDX_SCOPE_PRIO)) begin
      ctrl2_q <= pwdata[7:0];
    end else if (flush_done && (trig_q != ATF_TRIG_RST)) begin
      ctrl2_q[ATF_SCOPE_LSB +: 2] <= ATF_SCOPE_NONE;
    end
  end

  // flush triggers, self-clearing at the end of the flush
  always_ff @(posedge mclk) begin
    if (rst) begin
      trig_q <= ATF_TRIG_RST;
    end else if (wr_en && hit(paddr, ATF_IDX_FLUSH_TRIG)) begin
      trig_q <= trig_q | pwdata[1:0];
    end else if (flush_done) begin
      trig_q <= ATF_TRIG_RST;
    end
  end

  // flush command, scope applied to both triggers
  always_comb begin
    flush_cmd.active    = |trig_q;
    flush_cmd.dynamic   = (|trig_q) && (scope == ATF_SCOPE_DYN || scope == ATF_SCOPE_BOTH);
    flush_cmd.stat      = (|trig_q) && (scope == ATF_SCOPE_STAT || scope == ATF_SCOPE_BOTH);
    flush_cmd.mstp_only = trig_q[ATF_TRIG_MSTP] && !trig_q[ATF_TRIG_WHOLE];
  end

  // address based priority
  always_ff @(posedge mclk) begin
    if (rst) begin
      prio_q <= '0;
    end else begin
      case (psrc)
        ATF_PSRC_DA:  prio_q <= da_prio;
        ATF_PSRC_SA:  prio_q <= sa_prio;
        ATF_PSRC_MAX: prio_q <= (da_prio > sa_prio) ? da_prio : sa_prio;
        ATF_PSRC_MIN: prio_q <= (da_prio < sa_prio) ? da_prio : sa_prio;
        default:      prio_q <= da_prio;
      endcase
    end
  end
  assign address_based_priority = prio_q;

  // age period
  always_ff @(posedge mclk) begin
    if (rst) begin
      age_q <= ATF_RST_AGE;
    end else if (wr_en && hit(paddr, ATF_IDX_AGE_PERIOD)) begin
      age_q <= pwdata[7:0];
    end
  end
  assign age_period = age_q;

  // one tick per age period; the table steps each entry's age count on it
  always_ff @(posedge mclk) begin
    if (rst) begin
      sec_cnt_q  <= 32'h0;
      age_cnt_q  <= 8'h0;
      age_tick_q <= 1'b0;
    end else begin
      age_tick_q <= 1'b0;
      if (sec_cnt_q == 32'(SEC_CYCLES - 1)) begin
        sec_cnt_q <= 32'h0;
        if (age_q != 8'h0 && age_cnt_q >= age_q - 8'h1) begin
          age_cnt_q  <= 8'h0;
          age_tick_q <= 1'b1;
        end else begin
          age_cnt_q <= age_cnt_q + 8'h1;
        end
      end else begin
        sec_cnt_q <= sec_cnt_q + 32'h1;
      end
    end
  end
  assign age_tick = age_tick_q;

  // cycles between ticks; an age period write spoils the next gap
  logic [39:0] tick_gap_q;
  logic        gap_clean_q;
  logic [39:0] age_span;
  assign age_span = 40'(age_q) * 40'(SEC_CYCLES);

  always_ff @(posedge mclk) begin
    if (rst) begin
      tick_gap_q <= 40'h0;
    end else if (age_tick_q) begin
      tick_gap_q <= 40'h1;
    end else begin
      tick_gap_q <= tick_gap_q + 40'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      gap_clean_q <= 1'b1;
    end else if (wr_en && hit(paddr, ATF_IDX_AGE_PERIOD)) begin
      gap_clean_q <= 1'b0;
    end else if (age_tick_q) begin
      gap_clean_q <= 1'b1;
    end
  end

  // event detection
  assign almost_ev = evt.st_wr_ok && (evt.st_wr_prior == ATF_ALMOST_LO
                                   || evt.st_wr_prior == ATF_ALMOST_HI);
  always_comb begin
    evt_set = '0;
    evt_set[ATF_EVT_LEARN]   = evt.learn_fail;
    evt_set[ATF_EVT_ALMOST]  = almost_ev;
    evt_set[ATF_EVT_WR_FAIL] = evt.st_wr_fail;
  end

  // sticky status, set beats write-one clear
  always_comb begin
    sts_d = sts_q;
    if (wr_en && hit(paddr, ATF_IDX_EVT_STATUS)) begin
      sts_d = sts_q & ~pwdata[ATF_EVT_N-1:0];
    end
    sts_d = sts_d | evt_set;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sts_q <= '0;
    end else begin
      sts_q <= sts_d;
    end
  end

  // masks
  always_ff @(posedge mclk) begin
    if (rst) begin
      mask_q <= ATF_RST_MASK;
    end else if (wr_en && hit(paddr, ATF_IDX_EVT_MASK)) begin
      mask_q <= pwdata[ATF_EVT_N-1:0];
    end
  end

  assign lookup_engine_summary_interrupt = |sts_q;
  assign irq = |(sts_q & ~mask_q);

  // index capture
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_idx_q <= 16'h0;
    end else if (evt.st_wr_fail) begin
      wr_idx_q <= {6'h0, evt.st_fail_bucket};
    end else if (almost_ev) begin
      wr_idx_q <= {4'h0, evt.st_wr_entry};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      learn_idx_q <= 16'h0;
    end else if (evt.learn_fail) begin
      learn_idx_q <= {6'h0, evt.learn_bucket};
    end
  end

  // checks
  a_learn_sets: assert property (@(posedge mclk) disable iff (rst)
    evt.learn_fail |=> sts_q[ATF_EVT_LEARN] && learn_idx_q[9:0] == $past(evt.learn_bucket))
    else $error("learn fail not recorded");
  a_almost_sets: assert property (@(posedge mclk) disable iff (rst)
    (evt.st_wr_ok && evt.st_wr_prior == 3'h3 && !evt.st_wr_fail)
      |=> sts_q[ATF_EVT_ALMOST] && wr_idx_q == {4'h0, $past(evt.st_wr_entry)})
    else $error("almost full not recorded");
  a_almost_quiet: assert property (@(posedge mclk) disable iff (rst)
    (!sts_q[ATF_EVT_ALMOST] && evt.st_wr_ok && evt.st_wr_prior > 3'h3)
      |=> !sts_q[ATF_EVT_ALMOST])
    else $error("almost full set on wrong count");
  a_wrfail_sets: assert property (@(posedge mclk) disable iff (rst)
    evt.st_wr_fail |=> sts_q[ATF_EVT_WR_FAIL] && wr_idx_q[15:10] == 6'h0)
    else $error("write fail not recorded");
  a_set_beats_clr: assert property (@(posedge mclk) disable iff (rst)
    (wr_en && hit(paddr, ATF_IDX_EVT_STATUS) && pwdata[0] && evt.st_wr_fail)
      |=> sts_q[0])
    else $error("clear won over event");
  a_sticky_hold: assert property (@(posedge mclk) disable iff (rst)
    (sts_q[1] && !(wr_en && hit(paddr, ATF_IDX_EVT_STATUS))) |=> sts_q[1])
    else $error("status dropped without clear");
  a_irq_mask: assert property (@(posedge mclk) disable iff (rst)
    irq == ((sts_q[2] && !mask_q[2]) || (sts_q[1] && !mask_q[1]) || (sts_q[0] && !mask_q[0])))
    else $error("interrupt disagrees with mask");
  a_summary_or: assert property (@(posedge mclk) disable iff (rst)
    lookup_engine_summary_interrupt == (sts_q != 3'h0))
    else $error("summary is not the or");
  a_prio_max: assert property (@(posedge mclk) disable iff (rst)
    (psrc == ATF_PSRC_MAX) |=> prio_q >= $past(da_prio) && prio_q >= $past(sa_prio))
    else $error("max priority wrong");
  a_prio_src: assert property (@(posedge mclk) disable iff (rst)
    (psrc == ATF_PSRC_SA) |=> prio_q == $past(sa_prio))
    else $error("source priority wrong");
  a_flush_scope: assert property (@(posedge mclk) disable iff (rst)
    (flush_cmd.active && scope == ATF_SCOPE_DYN) |-> flush_cmd.dynamic && !flush_cmd.stat)
    else $error("dynamic scope wrong");
  a_trig_clear: assert property (@(posedge mclk) disable iff (rst)
    (flush_done && flush_cmd.active && !wr_en) |=> !flush_cmd.active && scope == ATF_SCOPE_NONE)
    else $error("flush did not end");
  a_trig_hold: assert property (@(posedge mclk) disable iff (rst)
    (flush_cmd.active && !flush_done) |=> flush_cmd.active)
    else $error("flush dropped early");
  a_age_reset: assert property (@(posedge mclk)
    rst |=> age_q == 8'h4b && mask_q == 3'h7)
    else $error("reset values wrong");
  a_rsvd_zero: assert property (@(posedge mclk) disable iff (rst)
    (setup && !pwrite && hit(paddr, ATF_IDX_EVT_MASK)) |=> prdata_q[31:3] == 29'h0)
    else $error("reserved bits not zero");
  a_rsvd_status: assert property (@(posedge mclk) disable iff (rst)
    (setup && !pwrite && hit(paddr, ATF_IDX_EVT_STATUS)) |=> prdata_q[31:3] == 29'h0)
    else $error("status reserved bits not zero");
  a_wrfail_index: assert property (@(posedge mclk) disable iff (rst)
    evt.st_wr_fail |=> wr_idx_q == {6'h0, $past(evt.st_fail_bucket)})
    else $error("fail bucket not recorded");
  a_almost_low: assert property (@(posedge mclk) disable iff (rst)
    (evt.st_wr_ok && evt.st_wr_prior == ATF_ALMOST_LO && !evt.st_wr_fail)
      |=> sts_q[ATF_EVT_ALMOST] && wr_idx_q == {4'h0, $past(evt.st_wr_entry)})
    else $error("almost full at two not recorded");
  a_prio_min: assert property (@(posedge mclk) disable iff (rst)
    (psrc == ATF_PSRC_MIN) |=> prio_q <= $past(da_prio) && prio_q <= $past(sa_prio))
    else $error("min priority wrong");
  a_prio_dst: assert property (@(posedge mclk) disable iff (rst)
    (psrc == ATF_PSRC_DA) |=> prio_q == $past(da_prio))
    else $error("destination priority wrong");
  a_flush_static: assert property (@(posedge mclk) disable iff (rst)
    (flush_cmd.active && scope == ATF_SCOPE_STAT) |-> !flush_cmd.dynamic && flush_cmd.stat)
    else $error("static scope wrong");
  a_flush_both: assert property (@(posedge mclk) disable iff (rst)
    (flush_cmd.active && scope == ATF_SCOPE_BOTH) |-> flush_cmd.dynamic && flush_cmd.stat)
    else $error("both scope wrong");
  a_flush_none: assert property (@(posedge mclk) disable iff (rst)
    (scope == ATF_SCOPE_NONE) |-> !flush_cmd.dynamic && !flush_cmd.stat)
    else $error("idle scope flushes");
  a_sticky_learn: assert property (@(posedge mclk) disable iff (rst)
    (sts_q[2] && !(wr_en && hit(paddr, ATF_IDX_EVT_STATUS))) |=> sts_q[2])
    else $error("learn status dropped without clear");
  a_sticky_fail: assert property (@(posedge mclk) disable iff (rst)
    (sts_q[0] && !(wr_en && hit(paddr, ATF_IDX_EVT_STATUS))) |=> sts_q[0])
    else $error("fail status dropped without clear");
  a_trig_set: assert property (@(posedge mclk) disable iff (rst)
    (wr_en && hit(paddr, ATF_IDX_FLUSH_TRIG) && |pwdata[1:0]) |=> flush_cmd.active)
    else $error("trigger write did not start flush");
  a_age_gap: assert property (@(posedge mclk) disable iff (rst)
    (age_tick && gap_clean_q) |-> tick_gap_q == age_span)
    else $error("age tick spacing wrong");
  a_age_nonzero: assert property (@(posedge mclk) disable iff (rst)
    age_tick |-> $past(age_q) != 8'h0)
    else $error("tick with zero age period");

  c_irq_fires: cover property (@(posedge mclk) disable iff (rst) $rose(irq));
  c_flush_done: cover property (@(posedge mclk) disable iff (rst) flush_cmd.active ##1 flush_done);
  c_age_tick: cover property (@(posedge mclk) disable iff (rst) age_tick);
  c_scope_none: cover property (@(posedge mclk) disable iff (rst)
    flush_cmd.active && scope == ATF_SCOPE_NONE);
  c_set_clr: cover property (@(posedge mclk) disable iff (rst)
    wr_en && hit(paddr, ATF_IDX_EVT_STATUS) && |evt_set);

endmodule // atf_regs
`default_nettype wire

/* File: verification/atf_regs_tb_top.sv */
// self-checking bench for the table event, flush, priority and aging register bank
// assumes atf_pkg compiled first, one 200 MHz clock, APB master driven here
`timescale 1ns/1ps
`default_nettype none
module atf_regs_tb_top
  import atf_pkg::*;
;
  logic        mclk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  atf_evt_t    evt;
  logic [1:0]  da_prio;
  logic [1:0]  sa_prio;
  logic [1:0]  address_based_priority;
  atf_flush_t  flush_cmd;
  logic        flush_done;
  logic [7:0]  age_period;
  logic        age_tick;
  logic        lookup_engine_summary_interrupt;
  logic        irq;
  int          fails;
  int          check_count;
  int          cycles;
  logic [31:0] rd;
  logic        er;

  atf_regs #(.PRIO_W(2), .SEC_CYCLES(10)) i_dut (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .evt(evt), .da_prio(da_prio), .sa_prio(sa_prio),
    .address_based_priority(address_based_priority), .flush_cmd(flush_cmd),
    .flush_done(flush_done), .age_period(age_period), .age_tick(age_tick),
    .lookup_engine_summary_interrupt(lookup_engine_summary_interrupt), .irq(irq)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      stop_test();
    end
  end

  function automatic logic [31:0] ba(logic [11:0] i);
    return {18'h0, i, 2'h0};
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
    check_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      fails++;
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // one transfer; result taken at the edge where pready is seen high
  task automatic apb(logic wr, logic [31:0] a, logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(logic [11:0] i, logic [31:0] d);
    apb(1'b1, ba(i), d, rd, er);
  endtask

  task automatic rdc(logic [11:0] i, logic [31:0] exp, string what);
    apb(1'b0, ba(i), 32'h0, rd, er);
    chk({31'h0, er}, 32'h0, "slave error");
    chk(rd, exp, what);
  endtask

  task automatic pulse(atf_evt_t e);
    @(posedge mclk);
    evt <= e;
    @(posedge mclk);
    evt <= '0;
    #1;
  endtask

  task automatic t_defaults();
    rdc(ATF_IDX_AGE_PERIOD, 32'h4b, "age reset");
    rdc(ATF_IDX_EVT_MASK, 32'h7, "mask reset");
    rdc(ATF_IDX_SCOPE_PRIO, 32'h0, "ctrl reset");
    rdc(ATF_IDX_EVT_STATUS, 32'h0, "status reset");
    rdc(ATF_IDX_WR_INDEX, 32'h0, "index0 reset");
    rdc(ATF_IDX_LEARN_INDEX, 32'h0, "index1 reset");
    apb(1'b0, 32'h0000_0c5c, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    wr(ATF_IDX_EVT_MASK, 32'hffff_fff8);
    rdc(ATF_IDX_EVT_MASK, 32'h0, "mask reserved");
    wr(ATF_IDX_EVT_MASK, 32'h7);
  endtask

  task automatic t_prio();
    logic [1:0] exp [8] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h2, 2'h1, 2'h2, 2'h1};
    for (int s = 0; s < 8; s++) begin
      da_prio <= (s < 4) ? 2'h1 : 2'h2;
      sa_prio <= (s < 4) ? 2'h2 : 2'h1;
      wr(ATF_IDX_SCOPE_PRIO, 32'(s % 4));
      tick(3);
      chk({30'h0, address_based_priority}, {30'h0, exp[s]}, "priority");
    end
    wr(ATF_IDX_SCOPE_PRIO, 32'h0);
  endtask

  task automatic t_flush();
    for (int s = 0; s < 5; s++) begin
      wr(ATF_IDX_SCOPE_PRIO, 32'((s == 4 ? 1 : s) << 2));
      wr(ATF_IDX_FLUSH_TRIG, (s == 4) ? 32'h2 : 32'h1);
      tick(1);
      chk({31'h0, flush_cmd.active}, 32'h1, "flush active");
      chk({31'h0, flush_cmd.dynamic}, 32'((s == 4) || s[0]), "dynamic class");
      chk({31'h0, flush_cmd.stat}, 32'((s != 4) && s[1]), "static class");
      chk({31'h0, flush_cmd.mstp_only}, 32'(s == 4), "mstp only");
      @(posedge mclk);
      flush_done <= 1'b1;
      @(posedge mclk);
      flush_done <= 1'b0;
      tick(1);
      chk({31'h0, flush_cmd.active}, 32'h0, "flush ended");
      rdc(ATF_IDX_SCOPE_PRIO, 32'h0, "scope done");
      rdc(ATF_IDX_FLUSH_TRIG, 32'h0, "trigger cleared");
    end
  endtask

  task automatic t_events();
    atf_evt_t e;
    e = '0; e.st_wr_fail = 1'b1; e.st_fail_bucket = 10'h2a5;
    pulse(e);
    chk({30'h0, irq, lookup_engine_summary_interrupt}, 32'h1, "masked fail");
    rdc(ATF_IDX_WR_INDEX, 32'h2a5, "fail bucket");
    wr(ATF_IDX_EVT_MASK, 32'h6);
    tick(1);
    chk({31'h0, irq}, 32'h1, "unmasked irq");
    wr(ATF_IDX_EVT_STATUS, 32'h1);
    tick(1);
    chk({30'h0, irq, lookup_engine_summary_interrupt}, 32'h0, "cleared");
    fork
      wr(ATF_IDX_EVT_STATUS, 32'h1);
      begin
        repeat (2) @(posedge mclk);
        evt <= e;
        @(posedge mclk);
        evt <= '0;
      end
    join
    rdc(ATF_IDX_EVT_STATUS, 32'h1, "set beats clear");
    wr(ATF_IDX_EVT_STATUS, 32'h1);
    for (int p = 0; p < 5; p++) begin
      e = '0; e.st_wr_ok = 1'b1; e.st_wr_prior = 3'(p); e.st_wr_entry = 12'hab0 + 12'(p);
      pulse(e);
      rdc(ATF_IDX_EVT_STATUS, (p == 2 || p == 3) ? 32'h2 : 32'h0, "almost full");
      if (p == 3) rdc(ATF_IDX_WR_INDEX, 32'hab3, "almost index");
      wr(ATF_IDX_EVT_STATUS, 32'h2);
    end
    e = '0; e.learn_fail = 1'b1; e.learn_bucket = 10'h13f;
    wr(ATF_IDX_EVT_MASK, 32'h3);
    pulse(e);
    chk({30'h0, irq, lookup_engine_summary_interrupt}, 32'h3, "learn irq");
    rdc(ATF_IDX_EVT_STATUS, 32'h4, "learn status");
    rdc(ATF_IDX_LEARN_INDEX, 32'h13f, "learn bucket");
    wr(ATF_IDX_EVT_STATUS, 32'hff);
    rdc(ATF_IDX_EVT_STATUS, 32'h0, "all cleared");
  endtask

  task automatic t_age();
    int n;
    wr(ATF_IDX_AGE_PERIOD, 32'h2);
    rdc(ATF_IDX_AGE_PERIOD, 32'h2, "age write");
    chk({24'h0, age_period}, 32'h2, "age port");
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (age_tick !== 1'b1 && n < 100);
    end
    chk(32'(n), 32'h14, "tick spacing");
  endtask

  initial begin
    cycles = 0;
    fails = 0;
    check_count = 0;
    rst = 1'b1;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0; pwdata = 32'h0;
    evt = '0; da_prio = 2'h0; sa_prio = 2'h0; flush_done = 1'b0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_defaults();
    t_prio();
    t_flush();
    t_events();
    t_age();
    tick(2);
    stop_test();
  end
endmodule // atf_regs_tb_top
`default_nettype wire
